// ---- nco_far_side.sv ----
// Far-side model: input clock sources and the output pin wire
`timescale 1ns/100ps
`default_nettype none
module nco_far_side
  import nco_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic pin_out_i,
  input  wire logic pin_oe_i,
  output var logic  src_fast_o,
  output var logic  src_cell_o,
  output var logic  src_pin_o,
  output logic      pin_wire_o
);
  // ****************
  // Sources and pin
  // ****************
  logic pin_last_q;
  initial begin
    src_fast_o = 1'b0;
    src_cell_o = 1'b0;
    src_pin_o  = 1'b0;
    pin_last_q = 1'b0;
  end
  always @(posedge sys_clk_i) begin
    if (pin_oe_i) pin_last_q <= pin_out_i;
  end
  // Released pin shows the inverse of its last level, never a held value
  assign pin_wire_o = pin_oe_i ? pin_out_i : ~pin_last_q;

  task automatic drive(input logic [1:0] sel, input logic lvl);
    case (sel)
      SRC_FAST_OSC:   src_fast_o <= lvl;
      SRC_LOGIC_CELL: src_cell_o <= lvl;
      default:        src_pin_o  <= lvl;
    endcase
  endtask : drive

  // Sources stand still between bursts; 16 system cycles per period
  task automatic pulses(input logic [1:0] sel, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk_i);
      drive(sel, 1'b1);
      repeat (8) @(posedge sys_clk_i);
      drive(sel, 1'b0);
      repeat (7) @(posedge sys_clk_i);
    end
  endtask : pulses
endmodule : nco_far_side
`default_nettype wire

// ---- nco_pkg.sv ----
// Package: register map, field layout and types of the numerically controlled oscillator
package nco_pkg;

  // ************************************************************
  // Bus and data widths
  // ************************************************************
  localparam int unsigned ADDR_W   = 5;
  localparam int unsigned ACC_W    = 20;
  localparam int unsigned STEP_W   = 16;
  localparam int unsigned PCNT_W   = 8;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [ADDR_W-1:0] OFS_CONTROL   = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CLOCK     = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_PH_LOW    = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_PH_HIGH   = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_PH_UPPER  = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_STEP_LOW  = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_STEP_HIGH = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ       = 5'h1c;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int unsigned ON_BIT    = 7;
  localparam int unsigned PIN_BIT   = 6;
  localparam int unsigned LEVEL_BIT = 5;
  localparam int unsigned POL_BIT   = 4;
  localparam int unsigned PFM_BIT   = 0;
  localparam int unsigned PWS_LSB   = 5;
  localparam int unsigned CKS_LSB   = 0;
  localparam int unsigned FLAG_BIT  = 0;
  localparam int unsigned OIE_BIT   = 1;
  localparam int unsigned PIE_BIT   = 2;
  localparam int unsigned GIE_BIT   = 3;

  // ************************************************************
  // Clock source codes
  // ************************************************************
  localparam logic [1:0] SRC_FAST_OSC   = 2'h0;
  localparam logic [1:0] SRC_SYSTEM     = 2'h1;
  localparam logic [1:0] SRC_LOGIC_CELL = 2'h2;
  localparam logic [1:0] SRC_EXT_PIN    = 2'h3;

  // ************************************************************
  // Reset values and counts
  // ************************************************************
  localparam logic [7:0]  BYTE_RST   = 8'h00;
  localparam logic [31:0] WORD_RST   = 32'h0000_0000;
  localparam int unsigned SYNC_CNT   = 2;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic module_on;
    logic pin_drive_on;
    logic output_polarity;
    logic pulse_mode_select;
  } osc_control_t;

  typedef struct packed {
    logic [2:0] pulse_width_select;
    logic [1:0] clock_source_select;
  } osc_clock_control_t;

  typedef struct packed {
    logic overflow_irq_on;
    logic peripheral_irq_on;
    logic global_irq_on;
  } irq_enable_t;

  typedef enum logic [1:0] {
    PULSE_IDLE,
    PULSE_ARMED,
    PULSE_ACTIVE
  } pulse_state_t;

endpackage : nco_pkg

// ---- nco_props.sv ----
// Checker: bus handshake and output relations of the oscillator
`timescale 1ns/100ps
`default_nettype none
module nco_props
  import nco_pkg::*;
(
  input wire logic              sys_clk_i,
  input wire logic              rstn_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic              avs_read_i,
  input wire logic              avs_write_i,
  input wire logic [31:0]       avs_writedata_i,
  input wire logic [3:0]        avs_byteenable_i,
  input wire logic [31:0]       avs_readdata_o,
  input wire logic              avs_waitrequest_o,
  input wire logic              output_level_o,
  input wire logic              pin_out_o,
  input wire logic              pin_oe_o,
  input wire logic              irq_o
);
  // ****************
  // Properties
  // ****************
  logic wr_done;
  logic rd_done;
  assign wr_done = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  assign rd_done = avs_read_i && !avs_waitrequest_o;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("request not answered after one wait cycle");
  a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_wait_cause: assert property (!avs_waitrequest_o |-> avs_read_i || avs_write_i)
    else $error("waitrequest low without a request");
  a_level_read: assert property (rd_done && avs_address_i == OFS_CONTROL
    |-> avs_readdata_o[LEVEL_BIT] == $past(output_level_o))
    else $error("status bit differs from output level");
  a_oe_follow: assert property (wr_done && avs_address_i == OFS_CONTROL
    |-> ##2 pin_oe_o == $past(avs_writedata_i[PIN_BIT], 2))
    else $error("pin enable does not follow control write");
  // Enables off must silence the request even if the flag stays set
  a_irq_off: assert property (wr_done && avs_address_i == OFS_IRQ
    && avs_writedata_i[3:1] == 3'h0 |-> ##2 !irq_o [*2])
    else $error("request stays high with enables cleared");
  a_upper_pad: assert property (rd_done && avs_address_i == OFS_PH_UPPER
    |-> avs_readdata_o[31:4] == 28'h0000000) else $error("upper phase pad not zero");
  a_ctrl_pad: assert property (rd_done && avs_address_i == OFS_CONTROL
    |-> avs_readdata_o[31:8] == 24'h000000 && avs_readdata_o[3:1] == 3'h0)
    else $error("control unused bits not zero");
  a_clock_pad: assert property (rd_done && avs_address_i == OFS_CLOCK
    |-> avs_readdata_o[31:8] == 24'h000000 && avs_readdata_o[4:2] == 3'h0)
    else $error("clock control unused bits not zero");
endmodule : nco_props

bind numeric_controlled_oscillator nco_props nco_props_inst (.*);
`default_nettype wire

// ---- numeric_controlled_oscillator.sv ----
// Numerically controlled oscillator with an Avalon-MM register slave
`timescale 1ns/100ps
`default_nettype none

// How it works
// - A 20-bit phase accumulator, read and written as low, high and upper bytes.
// - A 16-bit step held in two readable, writable byte registers.
// - Each selected input clock edge adds the working step into the accumulator.
// - The addition carry is the overflow event behind every output and the flag.
// - Input clock comes from fast oscillator, system clock, logic cell or pin.
// - Source select codes 00 fast osc, 01 system, 10 logic cell, 11 pin.
// - While disabled, a write to either step register loads the working step at once.
// - While enabled, high byte first; low byte write transfers both on next edge.
// - The working step is hidden; software only sees the two step registers.
// - With pulse mode clear, the output toggles on each overflow.
// - With pulse mode set, each overflow gives an active pulse of selected width.
// - The pulse starts at the first input clock edge after the overflow.
// - The three-bit width field sets pulse width, ignored in fixed-duty mode.
// - Width code k gives 2 to the power k input clock periods.
// - Polarity set makes active high, clear makes active low, last stage.
// - Changing polarity with the overflow interrupt enabled raises the flag for that transition.
// - Final level reads in a status bit and feeds other peripherals.
// - Pin drive bit drives the final output on its pin, else leaves it undriven.
// - Module enable runs the accumulator; clear stops the module.
// - Overflow sets the flag; request needs enable and all three interrupt enables.
// - The flag stays set until software clears it.
// - Any reset clears every register to zero except wait_q, which resets to 1.
// - Runs on the system clock, which samples the selected clock's edges; it stops with the system clock.
// - Enabled with fast oscillator selected, that oscillator is held on in sleep.

module numeric_controlled_oscillator
  import nco_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              rstn_i,
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  input  wire logic              internal_fast_osc_i,
  input  wire logic              logic_cell_output_i,
  input  wire logic              external_clock_pin_i,
  output logic                   output_level_o,
  output logic                   pin_out_o,
  output logic                   pin_oe_o,
  output logic                   irq_o,
  output logic                   fast_osc_hold_o
);

  // ************************************************************
  // Declarations
  // ************************************************************
  osc_control_t       ctrl_q;
  osc_clock_control_t clk_ctrl_q;
  irq_enable_t        irq_en_q;
  pulse_state_t       pulse_q;

  logic [ACC_W-1:0]   acc_q;
  logic [ACC_W:0]     sum;
  logic [STEP_W-1:0]  step_q;
  logic [STEP_W-1:0]  step_work_q;
  logic               step_pend_q;
  logic [PCNT_W-1:0]  pulse_cnt_q;
  logic               toggle_q;
  logic               flag_q;
  logic               level_q;
  logic               level_d;
  logic               raw_level;
  logic               wait_q;
  logic [31:0]        rdata_q;
  logic               pin_oe_q;
  logic               irq_q;
  logic               hold_q;

  logic [2:0]         sync1_q;
  logic [2:0]         sync2_q;
  logic [2:0]         sync3_q;
  logic [2:0]         rise;

  logic               tick;
  logic               carry;
  logic               wr_en;
  logic               rd_en;
  logic               byte_wr;
  logic [7:0]         wbyte;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic hit(input logic [ADDR_W-1:0] ofs);
    hit = (avs_address_i == ofs);
  endfunction : hit

  // ************************************************************
  // Input clock synchronisers
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          sync3_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= (gi == 0) ? internal_fast_osc_i :
                         (gi == 1) ? logic_cell_output_i : external_clock_pin_i;
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
        end
      end
      assign rise[gi] = sync2_q[gi] & ~sync3_q[gi];
    end
  endgenerate

  // Sources are slower than the system clock; anything at half rate or above aliases
  always_comb begin
    case (clk_ctrl_q.clock_source_select)
      SRC_FAST_OSC:   tick = rise[0];
      SRC_SYSTEM:     tick = 1'b1;
      SRC_LOGIC_CELL: tick = rise[1];
      default:        tick = rise[2];
    endcase
  end

  // ************************************************************
  // Bus slave
  // ************************************************************
  assign wr_en   = avs_write_i & ~wait_q;
  assign rd_en   = avs_read_i & ~wait_q;
  assign byte_wr = wr_en & avs_byteenable_i[0];
  assign wbyte   = avs_writedata_i[7:0];

  // One wait cycle per access; data is ready at the releasing edge
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_q <= 1'b1;
    end else if ((avs_read_i | avs_write_i) & wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= WORD_RST;
    end else if (avs_read_i & wait_q) begin
      rdata_q <= WORD_RST;
      if (hit(OFS_CONTROL)) begin
        rdata_q[ON_BIT]    <= ctrl_q.module_on;
        rdata_q[PIN_BIT]   <= ctrl_q.pin_drive_on;
        rdata_q[LEVEL_BIT] <= level_q;
        rdata_q[POL_BIT]   <= ctrl_q.output_polarity;
        rdata_q[PFM_BIT]   <= ctrl_q.pulse_mode_select;
      end else if (hit(OFS_CLOCK)) begin
        rdata_q[PWS_LSB+:3] <= clk_ctrl_q.pulse_width_select;
        rdata_q[CKS_LSB+:2] <= clk_ctrl_q.clock_source_select;
      end else if (hit(OFS_PH_LOW)) begin
        rdata_q[7:0] <= acc_q[7:0];
      end else if (hit(OFS_PH_HIGH)) begin
        rdata_q[7:0] <= acc_q[15:8];
      end else if (hit(OFS_PH_UPPER)) begin
        rdata_q[3:0] <= acc_q[19:16];
      end else if (hit(OFS_STEP_LOW)) begin
        rdata_q[7:0] <= step_q[7:0];
      end else if (hit(OFS_STEP_HIGH)) begin
        rdata_q[7:0] <= step_q[15:8];
      end else if (hit(OFS_IRQ)) begin
        rdata_q[FLAG_BIT] <= flag_q;
        rdata_q[OIE_BIT]  <= irq_en_q.overflow_irq_on;
        rdata_q[PIE_BIT]  <= irq_en_q.peripheral_irq_on;
        rdata_q[GIE_BIT]  <= irq_en_q.global_irq_on;
      end
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q     <= '0;
      clk_ctrl_q <= '0;
      irq_en_q   <= '0;
    end else if (byte_wr) begin
      if (hit(OFS_CONTROL)) begin
        ctrl_q.module_on         <= wbyte[ON_BIT];
        ctrl_q.pin_drive_on      <= wbyte[PIN_BIT];
        ctrl_q.output_polarity   <= wbyte[POL_BIT];
        ctrl_q.pulse_mode_select <= wbyte[PFM_BIT];
      end else if (hit(OFS_CLOCK)) begin
        clk_ctrl_q.pulse_width_select  <= wbyte[PWS_LSB+:3];
        clk_ctrl_q.clock_source_select <= wbyte[CKS_LSB+:2];
      end else if (hit(OFS_IRQ)) begin
        irq_en_q.overflow_irq_on   <= wbyte[OIE_BIT];
        irq_en_q.peripheral_irq_on <= wbyte[PIE_BIT];
        irq_en_q.global_irq_on     <= wbyte[GIE_BIT];
      end
    end
  end

  // ************************************************************
  // Step registers and working buffer
  // ************************************************************
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      step_q <= '0;
    end else if (byte_wr & hit(OFS_STEP_LOW)) begin
      step_q[7:0] <= wbyte;
    end else if (byte_wr & hit(OFS_STEP_HIGH)) begin
      step_q[15:8] <= wbyte;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      step_work_q <= '0;
      step_pend_q <= 1'b0;
    end else if (!ctrl_q.module_on) begin
      step_pend_q <= 1'b0;
      if (byte_wr & hit(OFS_STEP_LOW)) begin
        step_work_q <= {step_q[15:8], wbyte};
      end else if (byte_wr & hit(OFS_STEP_HIGH)) begin
        step_work_q <= {wbyte, step_q[7:0]};
      end
    end else if (byte_wr & hit(OFS_STEP_LOW)) begin
      step_pend_q <= 1'b1;
    end else if (step_pend_q & tick) begin
      step_work_q <= step_q;
      step_pend_q <= 1'b0;
    end
  end

  // ************************************************************
  // Accumulator
  // ************************************************************
  assign sum   = {1'b0, acc_q} + {{(ACC_W-STEP_W+1){1'b0}}, step_work_q};
  assign carry = ctrl_q.module_on & tick & sum[ACC_W];

  // A software write wins over an addition in the same cycle
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_q <= '0;
    end else if (byte_wr & hit(OFS_PH_LOW)) begin
      acc_q[7:0] <= wbyte;
    end else if (byte_wr & hit(OFS_PH_HIGH)) begin
      acc_q[15:8] <= wbyte;
    end else if (byte_wr & hit(OFS_PH_UPPER)) begin
      acc_q[19:16] <= wbyte[3:0];
    end else if (ctrl_q.module_on & tick) begin
      acc_q <= sum[ACC_W-1:0];
    end
  end

  // ************************************************************
  // Output shaping
  // ************************************************************
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      toggle_q <= 1'b0;
    end else if (carry) begin
      toggle_q <= ~toggle_q;
    end
  end

  // Width overlap with the next overflow restarts the pulse
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pulse_q     <= PULSE_IDLE;
      pulse_cnt_q <= '0;
    end else if (carry) begin
      pulse_q <= PULSE_ARMED;
    end else if (tick & ctrl_q.module_on) begin
      case (pulse_q)
        PULSE_ARMED: begin
          pulse_q     <= PULSE_ACTIVE;
          pulse_cnt_q <= PCNT_W'((1 << clk_ctrl_q.pulse_width_select) - 1);
        end
        PULSE_ACTIVE: begin
          if (pulse_cnt_q == '0) begin
            pulse_q <= PULSE_IDLE;
          end else begin
            pulse_cnt_q <= pulse_cnt_q - 1'b1;
          end
        end
        default: begin
          pulse_q <= PULSE_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    if (ctrl_q.pulse_mode_select) begin
      raw_level = (pulse_q == PULSE_ACTIVE);
    end else begin
      raw_level = toggle_q;
    end
    level_d = ctrl_q.output_polarity ? raw_level : ~raw_level;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      level_q  <= 1'b0;
      pin_oe_q <= 1'b0;
      hold_q   <= 1'b0;
    end else begin
      level_q  <= level_d;
      pin_oe_q <= ctrl_q.pin_drive_on;
      hold_q   <= ctrl_q.module_on &
                  (clk_ctrl_q.clock_source_select == SRC_FAST_OSC);
    end
  end

  // ************************************************************
  // Overflow flag and request
  // ************************************************************
  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_q <= 1'b0;
    end else if (carry) begin
      flag_q <= 1'b1;
    end else if (byte_wr & hit(OFS_CONTROL) & irq_en_q.overflow_irq_on &
                 (wbyte[POL_BIT] != ctrl_q.output_polarity)) begin
      flag_q <= 1'b1;
    end else if (byte_wr & hit(OFS_IRQ) & wbyte[FLAG_BIT]) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= flag_q & ctrl_q.module_on & irq_en_q.overflow_irq_on &
               irq_en_q.peripheral_irq_on & irq_en_q.global_irq_on;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign output_level_o    = level_q;
  assign pin_out_o         = level_q;
  assign pin_oe_o          = pin_oe_q;
  assign irq_o             = irq_q;
  assign fast_osc_hold_o   = hold_q;

endmodule : numeric_controlled_oscillator

`default_nettype wire

// ---- tb_numeric_controlled_oscillator.sv ----
// Testbench: register access, accumulation, output modes and interrupts
`timescale 1ns/100ps
`default_nettype none
module tb_numeric_controlled_oscillator
  import nco_pkg::*;
;
  logic              sys_clk_i        = 1'b0;
  logic              rstn_i           = 1'b0;
  logic [ADDR_W-1:0] avs_address_i    = 5'h00;
  logic              avs_read_i       = 1'b0;
  logic              avs_write_i      = 1'b0;
  logic [31:0]       avs_writedata_i  = 32'h00000000;
  logic [3:0]        avs_byteenable_i = 4'h1;
  logic [31:0]       avs_readdata_o;
  logic              avs_waitrequest_o;
  wire logic         internal_fast_osc_i;
  wire logic         logic_cell_output_i;
  wire logic         external_clock_pin_i;
  wire logic         pin_wire;
  logic              output_level_o;
  logic              pin_out_o;
  logic              pin_oe_o;
  logic              irq_o;
  logic              fast_osc_hold_o;
  int                mismatches       = 0;
  int                checks           = 0;
  int                cyc              = 0;
  int                act_cnt          = 0;
  int                base;
  logic [ADDR_W-1:0] ta [8] = '{OFS_CLOCK, OFS_PH_LOW, OFS_PH_HIGH, OFS_PH_UPPER,
                                OFS_STEP_LOW, OFS_STEP_HIGH, OFS_CONTROL, OFS_IRQ};
  logic [7:0]        td [8] = '{8'hff, 8'hff, 8'ha5, 8'hff, 8'h5a, 8'hc3, 8'h7f, 8'hff};
  logic [7:0]        te [8] = '{8'he3, 8'hff, 8'ha5, 8'h0f, 8'h5a, 8'hc3, 8'h51, 8'h0e};

  numeric_controlled_oscillator numeric_controlled_oscillator_inst (.*);
  nco_far_side nco_far_side_inst (.sys_clk_i(sys_clk_i), .pin_out_i(pin_out_o),
    .pin_oe_i(pin_oe_o), .src_fast_o(internal_fast_osc_i), .src_cell_o(logic_cell_output_i),
    .src_pin_o(external_clock_pin_i), .pin_wire_o(pin_wire));

  always #2 sys_clk_i = ~sys_clk_i;

  // Runs near 5400 cycles; the ceiling leaves ample margin
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (output_level_o === 1'b1) act_cnt <= act_cnt + 1;
    if (cyc == 40000) begin
      mismatches++;
      final_report();
    end
  end

  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge sys_clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= {24'h000000, d};
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o[7:0];
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e,
                    input logic [7:0] m = 8'hff);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(16'(q & m), 16'(e));
  endtask : rd

  task automatic do_reset();
    @(posedge sys_clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
  endtask : do_reset

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  // ****************
  // Sequence
  // ****************
  initial begin
    do_reset();
    for (int i = 0; i < 8; i++) rd(5'(i * 4), (i == 0) ? 8'h20 : 8'h00);
    for (int i = 0; i < 8; i++) wr(ta[i], td[i]);
    for (int i = 0; i < 8; i++) rd(ta[i], te[i], (i == 6) ? 8'hdf : 8'hff);
    avs_byteenable_i <= 4'he;
    wr(OFS_STEP_LOW, 8'h00);
    avs_byteenable_i <= 4'h1;
    rd(OFS_STEP_LOW, 8'h5a);
    for (int s = 0; s < 4; s++) begin
      do_reset();
      wr(OFS_CLOCK, {3'h7, 3'h0, 2'(s)});
      wr(OFS_STEP_HIGH, 8'h10);
      wr(OFS_STEP_LOW, 8'h00);
      wr(OFS_PH_UPPER, 8'h0f);
      wr(OFS_PH_HIGH, 8'hf0);
      wr(OFS_CONTROL, 8'h50);
      nco_far_side_inst.pulses(2'(s), 2);
      wr(OFS_IRQ, 8'h0e);
      wr(OFS_CONTROL, 8'hd0);
      nco_far_side_inst.pulses(2'(s), 5);
      if (s != 1) begin
        chk(16'(irq_o), 16'h0001);
        chk(16'(output_level_o), 16'h0001);
        chk(16'(pin_wire), 16'h0001);
        chk(16'(fast_osc_hold_o), 16'(s == 0));
        wr(OFS_IRQ, 8'h0f);
        rd(OFS_IRQ, 8'h0e);
        wr(OFS_CONTROL, 8'hc0);
        rd(OFS_IRQ, 8'h0f);
        chk(16'(output_level_o), 16'h0000);
        wr(OFS_IRQ, 8'h01);
        rd(OFS_IRQ, 8'h00);
        wr(OFS_CONTROL, 8'h40);
        rd(OFS_PH_LOW, 8'h00);
        rd(OFS_PH_HIGH, 8'h40);
        rd(OFS_PH_UPPER, 8'h00);
        rd(OFS_CONTROL, 8'h40);
      end else begin
        wr(OFS_CONTROL, 8'h40);
        rd(OFS_PH_LOW, 8'h00);
        rd(OFS_PH_HIGH, 8'h00, 8'h0f);
      end
    end
    do_reset();
    wr(OFS_STEP_HIGH, 8'h10);
    wr(OFS_STEP_LOW, 8'h00);
    wr(OFS_CONTROL, 8'h80);
    wr(OFS_STEP_HIGH, 8'h30);
    nco_far_side_inst.pulses(SRC_FAST_OSC, 2);
    rd(OFS_PH_HIGH, 8'h20);
    rd(OFS_STEP_HIGH, 8'h30);
    chk(16'(pin_oe_o), 16'h0000);
    // Low byte arms the transfer; the next tick still adds the old step
    wr(OFS_STEP_LOW, 8'h00);
    nco_far_side_inst.pulses(SRC_FAST_OSC, 2);
    wr(OFS_CONTROL, 8'h00);
    rd(OFS_PH_HIGH, 8'h60);
    wr(OFS_STEP_HIGH, 8'h10);
    wr(OFS_CONTROL, 8'h80);
    nco_far_side_inst.pulses(SRC_FAST_OSC, 1);
    rd(OFS_PH_HIGH, 8'h70);
    for (int k = 0; k < 8; k++) begin
      do_reset();
      wr(OFS_CLOCK, {3'(k), 5'h00});
      wr(OFS_STEP_HIGH, 8'h10);
      wr(OFS_PH_UPPER, 8'h0f);
      wr(OFS_PH_HIGH, 8'hf0);
      wr(OFS_CONTROL, 8'hd1);
      repeat (2) @(posedge sys_clk_i);
      base = act_cnt;
      nco_far_side_inst.pulses(SRC_FAST_OSC, (1 << k) + 2);
      repeat (4) @(posedge sys_clk_i);
      chk(16'(act_cnt - base), 16'(16 << k));
    end
    final_report();
  end
endmodule : tb_numeric_controlled_oscillator
`default_nettype wire
